// *** logic/cksg_pkg.sv ***
// constants for the clock synthesizer gating and power-down control
// assumes a single 25 MHz system clock that stands in for the crystal reference
package cksg_pkg;

	// phase counter: host = bit 1, bus = bit 2, reference = bit 0
	localparam int          PHASE_W        = 3;
	localparam logic [2:0]  PHASE_RESET    = 3'h7;
	localparam logic [2:0]  PHASE_ALL_LOW  = 3'h7;
	localparam logic [1:0]  HOST_LOW_SLOT  = 2'h3;
	localparam int          REF_BIT        = 0;
	localparam int          HOST_BIT       = 1;
	localparam int          BUS_BIT        = 2;

	// frequency select encodings
	localparam logic [1:0]  SEL_HIZ        = 2'h0;
	localparam logic [1:0]  SEL_HOST_60    = 2'h1;
	localparam logic [1:0]  SEL_HOST_66    = 2'h2;
	localparam logic [1:0]  SEL_TEST       = 2'h3;

	// power-up latency must stay below this time
	localparam int          SYS_CLK_MHZ    = 25;
	localparam int          SYS_PERIOD_NS  = 1000 / SYS_CLK_MHZ;
	localparam int          PD_WAKE_MAX_NS = 3000000;
	localparam int          PD_WAKE_CYCLES = PD_WAKE_MAX_NS / SYS_PERIOD_NS - 1;
	localparam int          WAKE_CNT_W     = 17;

	typedef enum logic [1:0]
	{
		ST_RUN  = 2'b00,
		ST_PARK = 2'b01,
		ST_OFF  = 2'b10,
		ST_WAKE = 2'b11
	} cksg_state_t;

endpackage

// *** logic/cksg_ctrl.sv ***
// clock gating, mode select and power-down sequencing of a clock synthesizer
// assumes clk_sys is the free crystal-rate clock; the analog PLL follows the rate and run outputs
`timescale 1ns/1ps

module cksg_ctrl
	import cksg_pkg::*;
#(
	parameter int unsigned WAKE_CYCLES = PD_WAKE_CYCLES
)
(
	input  wire logic clk_sys,
	input  wire logic rst_n,
	input  wire logic freq_select_lo,
	input  wire logic freq_select_hi,
	input  wire logic host_clock_gate_in,
	input  wire logic bus_clock_gate_in,
	input  wire logic power_down_n,
	output logic      host_clock_out,
	output logic      bus_clock_out,
	output logic      reference_clock_out,
	output logic      interrupt_ctrl_clock_out,
	output logic      fixed24ClockOut,
	output logic      fixed48ClockOut,
	output logic      clockOutEnable,
	output logic      hostRate66,
	output logic      testModeActive,
	output logic      oscillatorRun,
	output logic      vcoRun,
	output logic      clocksValid
);

	////////////////////////////////////////////////////////////////////////////
	// synchronisers for the asynchronous gate and power-down inputs

	logic        hostGateMeta_r;
	logic        hostGateSync_r;
	logic        busGateMeta_r;
	logic        busGateSync_r;
	logic        pdMeta_r;
	logic        pdSync_r;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			hostGateMeta_r <= 1'b0;
			hostGateSync_r <= 1'b0;
			busGateMeta_r  <= 1'b0;
			busGateSync_r  <= 1'b0;
			pdMeta_r       <= 1'b1;
			pdSync_r       <= 1'b1;
		end
		else
		begin
			hostGateMeta_r <= host_clock_gate_in;
			hostGateSync_r <= hostGateMeta_r;
			busGateMeta_r  <= bus_clock_gate_in;
			busGateSync_r  <= busGateMeta_r;
			pdMeta_r       <= power_down_n;
			pdSync_r       <= pdMeta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// power-down sequencer, phase counter and gate enables

	cksg_state_t           state_r;
	cksg_state_t           state_nxt;
	logic [PHASE_W-1:0]    phase_r;
	logic [PHASE_W-1:0]    phase_nxt;
	logic [WAKE_CNT_W-1:0] wakeCnt_r;
	logic [WAKE_CNT_W-1:0] wakeCnt_nxt;
	logic                  hostEn_r;
	logic                  hostEn_nxt;
	logic                  busEn_r;
	logic                  busEn_nxt;
	logic                  allLowSlot;

	assign allLowSlot = (phase_r == PHASE_ALL_LOW);

	always_comb
	begin
		state_nxt   = state_r;
		phase_nxt   = phase_r + 3'h1;
		wakeCnt_nxt = wakeCnt_r;
		hostEn_nxt  = hostEn_r;
		busEn_nxt   = busEn_r;
		case (state_r)
			ST_RUN:
			begin
				// gates change only while the gated clock is low, just before a rising edge
				if (phase_r[1:0] == HOST_LOW_SLOT)
					hostEn_nxt = hostGateSync_r;
				if (allLowSlot)
					busEn_nxt = busGateSync_r;
				if (!pdSync_r && allLowSlot)
				begin
					state_nxt  = ST_PARK;
					hostEn_nxt = 1'b0;
					busEn_nxt  = 1'b0;
				end
			end
			ST_PARK:
			begin
				state_nxt  = ST_OFF;
				phase_nxt  = PHASE_RESET;
				hostEn_nxt = 1'b0;
				busEn_nxt  = 1'b0;
			end
			ST_OFF:
			begin
				phase_nxt   = PHASE_RESET;
				wakeCnt_nxt = '0;
				hostEn_nxt  = 1'b0;
				busEn_nxt   = 1'b0;
				if (pdSync_r)
					state_nxt = ST_WAKE;
			end
			ST_WAKE:
			begin
				hostEn_nxt = 1'b0;
				busEn_nxt  = 1'b0;
				if (wakeCnt_r < WAKE_CNT_W'(WAKE_CYCLES))
					wakeCnt_nxt = wakeCnt_r + 17'h00001;
				if (!pdSync_r)
					state_nxt = ST_PARK;
				else if (wakeCnt_r >= WAKE_CNT_W'(WAKE_CYCLES) && allLowSlot)
					state_nxt = ST_RUN;
			end
			default:
			begin
				state_nxt = ST_PARK;
			end
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_r   <= ST_RUN;
			phase_r   <= PHASE_RESET;
			wakeCnt_r <= '0;
			hostEn_r  <= 1'b0;
			busEn_r   <= 1'b0;
		end
		else
		begin
			state_r   <= state_nxt;
			phase_r   <= phase_nxt;
			wakeCnt_r <= wakeCnt_nxt;
			hostEn_r  <= hostEn_nxt;
			busEn_r   <= busEn_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// clock outputs and mode outputs, all registered

	logic [1:0] freqSel;
	logic       runNxt;
	logic       hostOut_nxt;
	logic       busOut_nxt;
	logic       refOut_nxt;
	logic       f24Out_nxt;
	logic       f48Out_nxt;
	logic       outEn_nxt;
	logic       rate66_nxt;
	logic       test_nxt;
	logic       osc_nxt;
	logic       valid_nxt;

	assign freqSel = {freq_select_hi, freq_select_lo};

	always_comb
	begin
		runNxt      = (state_nxt == ST_RUN);
		// every clock shares one phase, so the bus rises only on a host-rate (fixed48ClockOut) rising edge
		hostOut_nxt = hostEn_nxt & runNxt & ~phase_nxt[HOST_BIT];
		busOut_nxt  = busEn_nxt & runNxt & ~phase_nxt[BUS_BIT];
		refOut_nxt  = runNxt & ~phase_nxt[REF_BIT];
		f48Out_nxt  = runNxt & ~phase_nxt[HOST_BIT];
		f24Out_nxt  = runNxt & ~phase_nxt[BUS_BIT];
		outEn_nxt   = (freqSel != SEL_HIZ);
		rate66_nxt  = (freqSel == SEL_HOST_66);
		test_nxt    = (freqSel == SEL_TEST);
		osc_nxt     = (state_nxt != ST_OFF);
		valid_nxt   = runNxt;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			host_clock_out           <= 1'b0;
			bus_clock_out            <= 1'b0;
			reference_clock_out      <= 1'b0;
			interrupt_ctrl_clock_out <= 1'b0;
			fixed24ClockOut          <= 1'b0;
			fixed48ClockOut          <= 1'b0;
			clockOutEnable           <= 1'b0;
			hostRate66               <= 1'b0;
			testModeActive           <= 1'b0;
			oscillatorRun            <= 1'b1;
			vcoRun                   <= 1'b1;
			clocksValid              <= 1'b0;
		end
		else
		begin
			host_clock_out           <= hostOut_nxt;
			bus_clock_out            <= busOut_nxt;
			reference_clock_out      <= refOut_nxt;
			interrupt_ctrl_clock_out <= refOut_nxt;
			fixed24ClockOut          <= f24Out_nxt;
			fixed48ClockOut          <= f48Out_nxt;
			clockOutEnable           <= outEn_nxt;
			hostRate66               <= rate66_nxt;
			testModeActive           <= test_nxt;
			oscillatorRun            <= osc_nxt;
			vcoRun                   <= osc_nxt;
			clocksValid              <= valid_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence seqParkStep;
		(state_r == ST_RUN) ##1 (state_r == ST_PARK);
	endsequence

	sequence seqAllLowThenOff;
		!host_clock_out && !bus_clock_out && !reference_clock_out && oscillatorRun
		##1 (state_r == ST_OFF) && !oscillatorRun;
	endsequence

	chk_host_rate_sel: assert property (##1 (hostRate66 == $past(freqSel == SEL_HOST_66)))
		else $error("host rate select does not follow the selects");
	chk_bus_half_rate: assert property ($rose(bus_clock_out) |-> $rose(fixed48ClockOut))
		else $error("bus clock rose away from a host-rate rising edge");
	chk_test_mode_sel: assert property ((freqSel == SEL_TEST) |=> testModeActive)
		else $error("test mode not entered with both selects high");
	chk_hiz_outputs: assert property ((freqSel == SEL_HIZ) |=> !clockOutEnable)
		else $error("clock outputs driven with both selects low");
	chk_host_held_low: assert property (!hostEn_r |-> !host_clock_out)
		else $error("host clock high while gated off");
	chk_host_off_latency: assert property ((!hostGateSync_r && state_r == ST_RUN)[*5] |-> !hostEn_r)
		else $error("host clock not stopped in time");
	chk_host_on_latency: assert property ((hostGateSync_r && state_r == ST_RUN)[*5] |-> hostEn_r)
		else $error("host clock not started in time");
	chk_host_full_pulse: assert property ($rose(host_clock_out) |-> host_clock_out ##1 host_clock_out)
		else $error("runt high pulse on host clock");
	chk_host_stop_low: assert property ($fell(hostEn_r) |-> !host_clock_out && !$past(host_clock_out))
		else $error("host clock stopped from a high level");
	chk_others_running: assert property ((state_r == ST_RUN)[*2] |-> reference_clock_out != $past(reference_clock_out))
		else $error("reference clock stalled while running");
	chk_bus_full_pulse: assert property ($rose(bus_clock_out) |-> bus_clock_out[*4] ##1 !bus_clock_out)
		else $error("bus clock high pulse not full width");
	chk_bus_off_latency: assert property ((!busGateSync_r && state_r == ST_RUN)[*8] |=> !busEn_r)
		else $error("bus clock not stopped in time");
	chk_pd_entry_time: assert property ($fell(pdSync_r) && state_r == ST_RUN |-> ##[1:8] (state_r == ST_PARK))
		else $error("power-down entry too slow");
	chk_pd_order: assert property (seqParkStep |-> seqAllLowThenOff)
		else $error("oscillator stopped before clocks parked low");
	chk_wake_bound: assert property ((state_r == ST_WAKE) |-> wakeCnt_r <= WAKE_CNT_W'(WAKE_CYCLES))
		else $error("wake counter beyond power-up bound");
	chk_wake_exit: assert property ((state_r == ST_WAKE && wakeCnt_r >= WAKE_CNT_W'(WAKE_CYCLES)) |-> ##[1:8] (state_r != ST_WAKE))
		else $error("clocks not restarted after the wake count");
	chk_gates_ignored: assert property ((state_r != ST_RUN) |-> !hostEn_r && !busEn_r)
		else $error("gate enables active during power-down");
	chk_no_runt_wake: assert property ($rose(state_r == ST_RUN) |-> phase_r == '0)
		else $error("clocks restarted away from a rising edge");

endmodule

// *** dv/cksg_far_end.sv ***
// far-side control logic: drives the gate and power-down inputs of the block
// assumes requests come from the bench; levels change on the falling edge
`timescale 1ns/1ps
module cksg_far_end
	import cksg_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic reqHost,
	input  wire logic reqBus,
	input  wire logic reqPdn,
	output logic      host_clock_gate_in,
	output logic      bus_clock_gate_in,
	output logic      power_down_n
);
	localparam int HOST_MIN = 100 * 4;
	localparam int BUS_MIN  = 10 * 8;
	int            hostHeld;
	int            busHeld;

	initial
	begin
		host_clock_gate_in = 1'b0;
		bus_clock_gate_in = 1'b0;
		power_down_n = 1'b1;
		hostHeld = 0;
		busHeld = 0;
	end

	// a raised gate stays up for its minimum span
	always @(negedge clk_sys)
	begin
		hostHeld <= host_clock_gate_in ? hostHeld + 1 : 0;
		busHeld <= bus_clock_gate_in ? busHeld + 1 : 0;
		if (!host_clock_gate_in || hostHeld >= HOST_MIN)
			host_clock_gate_in <= reqHost;
		if (!bus_clock_gate_in || busHeld >= BUS_MIN)
			bus_clock_gate_in <= reqBus;
		power_down_n <= reqPdn;
	end
endmodule

// *** dv/clock_synth_gating_control_tb.sv ***
// self-checking bench of the clock gating and power-down control
// assumes the far-side model and a shortened wake count
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin failures++; $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module clock_synth_gating_control_tb
	import cksg_pkg::*;
;
	localparam int WAKE = 20;
	logic        clk_sys;
	logic        rst_n;
	logic        selLo;
	logic        selHi;
	logic        reqHost;
	logic        reqBus;
	logic        reqPdn;
	logic        hostGate;
	logic        busGate;
	logic        pdn;
	logic        hostOut;
	logic        busOut;
	logic        refOut;
	logic        icOut;
	logic        f24;
	logic        f48;
	logic        outEn;
	logic        rate66;
	logic        testOn;
	logic        oscRun;
	logic        vcoRun;
	logic        valid;
	logic [2:0]  ph;
	int          hostAge;
	int          busAge;
	int          pdAge;
	int          n;
	int          comparisons = 0;
	int          failures = 0;
	logic [31:0] lfsr;
	logic        lastHost;
	logic        lastBus;

	cksg_ctrl #(.WAKE_CYCLES(WAKE)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .freq_select_lo(selLo),
		.freq_select_hi(selHi), .host_clock_gate_in(hostGate), .bus_clock_gate_in(busGate),
		.power_down_n(pdn), .host_clock_out(hostOut), .bus_clock_out(busOut), .reference_clock_out(refOut),
		.interrupt_ctrl_clock_out(icOut), .fixed24ClockOut(f24), .fixed48ClockOut(f48),
		.clockOutEnable(outEn), .hostRate66(rate66), .testModeActive(testOn), .oscillatorRun(oscRun),
		.vcoRun(vcoRun), .clocksValid(valid));

	cksg_far_end i_far (.clk_sys(clk_sys), .reqHost(reqHost), .reqBus(reqBus), .reqPdn(reqPdn),
		.host_clock_gate_in(hostGate), .bus_clock_gate_in(busGate), .power_down_n(pdn));

	function automatic logic [31:0] nextLfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction

	task automatic end_of_test;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end

	////////////////////////////////////////////////////////////////////////////////
	// reference model: phase counter and gate settling ages
	always @(negedge clk_sys)
	begin
		hostAge = (valid === 1'b1 && hostGate === lastHost) ? hostAge + 1 : 0;
		busAge = (valid === 1'b1 && busGate === lastBus) ? busAge + 1 : 0;
		lastHost = hostGate;
		lastBus = busGate;
		pdAge = pdn ? 0 : pdAge + 1;
		if (!rst_n || valid !== 1'b1)
			ph = 3'h0;
		if (rst_n)
		begin
			`CHK(outEn, {selHi, selLo} != 2'h0)
			`CHK(rate66, {selHi, selLo} == 2'h2)
			`CHK(testOn, {selHi, selLo} == 2'h3)
			`CHK(!oscRun && (hostOut | busOut | refOut | icOut | f24 | f48), 1'b0)
			`CHK(vcoRun, oscRun)
			if (pdAge >= 12)
			begin
				`CHK({hostOut, busOut, refOut, icOut, f24, f48, oscRun}, 7'h00)
			end
			if (valid === 1'b1)
			begin
				`CHK({refOut, icOut, f48, f24}, {~ph[0], ~ph[0], ~ph[1], ~ph[2]})
				`CHK({hostOut & ph[1], busOut & ph[2], busOut & ~f24}, 3'h0)
				if (hostAge >= 8)
					`CHK(hostOut, hostGate & ~ph[1])
				if (busAge >= 12)
					`CHK(busOut, busGate & ~ph[2])
				ph = ph + 3'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// stimulus
	initial
	begin
		rst_n = 1'b0;
		{selHi, selLo} = 2'h1;
		{reqHost, reqBus, reqPdn} = 3'b001;
		{hostAge, busAge, pdAge} = 0;
		lfsr = 32'h29d6;
		repeat (3) @(negedge clk_sys);
		rst_n <= 1'b1;
		for (n = 0; n < 4; n++)
		begin
			@(negedge clk_sys);
			{selHi, selLo} <= n[1:0];
			repeat (3) @(negedge clk_sys);
		end
		repeat (40)
		begin
			@(negedge clk_sys);
			lfsr = nextLfsr(lfsr);
			{reqHost, reqBus} <= lfsr[1:0];
			{selHi, selLo} <= lfsr[3:2];
			repeat (lfsr[9:4]) @(negedge clk_sys);
		end
		{reqHost, reqBus} <= 2'b11;
		repeat (500) @(negedge clk_sys);
		reqPdn <= 1'b0;
		repeat (100) @(negedge clk_sys);
		reqPdn <= 1'b1;
		@(negedge clk_sys);
		for (n = 0; n < 200 && valid !== 1'b1; n++)
			@(negedge clk_sys);
		if (n == 200)
		begin
			failures++;
			end_of_test();
		end
		`CHK(n <= WAKE + 14, 1'b1)
		repeat (300) @(negedge clk_sys);
		end_of_test();
	end
endmodule
